// File: verilog/ibo_device.sv
// transceiver end: config register, slot counting, rx drive, tx capture
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ibo_device
  import ibo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ibo_if.dev bus,
  input wire logic [7:0] rx_chan_data,
  output logic rx_chan_req,
  output logic [4:0] rx_chan_idx,
  output logic [7:0] tx_chan_data,
  output logic tx_chan_valid,
  output logic [4:0] tx_chan_idx,
  output logic [7:0] cfg_value
);
  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  logic [6:0] cfg_q;
  logic [7:0] rdata_q;
  logic tcs;
  logic en;
  logic [1:0] rate;
  logic [2:0] pos;
  logic [1:0] eff_rate;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= IBO_CFG_RESET[6:0];
    else if (bus.cfg_wr && bus.cfg_addr == IBO_CFG_ADDR)
      cfg_q <= bus.cfg_wdata[6:0];
  end

  // [R9] unassigned bit reads zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (bus.cfg_rd && bus.cfg_addr == IBO_CFG_ADDR)
      rdata_q <= {1'b0, cfg_q};
    else
      rdata_q <= 8'h00;
  end
  assign bus.cfg_rdata = rdata_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_value <= IBO_CFG_RESET;
    else
      cfg_value <= {1'b0, cfg_q};
  end

  assign tcs = cfg_q[IBO_TCS_BIT];
  assign rate = cfg_q[IBO_RATE_HI:IBO_RATE_LO];
  assign en = cfg_q[IBO_EN_BIT];
  assign pos = cfg_q[IBO_POS_HI:IBO_POS_LO];
  // [R3] disabled means one plain stream
  assign eff_rate = en ? rate : IBO_RATE_2M;

  // ----------------------------------------
  // receive bus bit counter
  // ----------------------------------------
  logic bp_prev_q;
  logic bp_rise;
  logic [IBO_CNT_W-1:0] cnt_q;
  logic [IBO_CNT_W-1:0] cnt_d;
  logic [2:0] slot_d;
  logic mine_d;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bp_prev_q <= 1'b0;
    else
      bp_prev_q <= bus.bp_clk;
  end
  assign bp_rise = bus.bp_clk && !bp_prev_q;

  // [R2] frame length follows rate field
  always_comb
  begin
    if (bus.frame_sync || cnt_q == ibo_frame_last(eff_rate))
      cnt_d = '0;
    else
      cnt_d = cnt_q + IBO_CNT_W'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (bp_rise)
      cnt_q <= cnt_d;
  end

  // [R1] slot changes every channel byte
  assign slot_d = cnt_d[5:3] & ibo_slot_mask(eff_rate);
  // [R5] exclusive position keeps drives apart
  // [R4] compare slot to assigned position
  assign mine_d = (slot_d == pos) || (eff_rate == IBO_RATE_2M);

  // ----------------------------------------
  // receive bus drive
  // ----------------------------------------
  logic [7:0] rx_sh_q;
  logic rx_d_q;
  logic rx_oe_q;

  // [R10] drive only inside own slot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_d_q <= 1'b1;
      rx_oe_q <= 1'b0;
      rx_sh_q <= IBO_IDLE_BYTE;
    end
    else if (bp_rise)
    begin
      rx_oe_q <= mine_d;
      if (mine_d && cnt_d[2:0] == 3'h0)
      begin
        rx_sh_q <= {rx_chan_data[6:0], 1'b1};
        rx_d_q <= rx_chan_data[7];
      end
      else if (mine_d)
      begin
        rx_sh_q <= {rx_sh_q[6:0], 1'b1};
        rx_d_q <= rx_sh_q[7];
      end
      else
        rx_d_q <= 1'b1;
    end
  end
  assign bus.rx_d = rx_d_q;
  assign bus.rx_oe = rx_oe_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_chan_req <= 1'b0;
      rx_chan_idx <= 5'h00;
    end
    else
    begin
      rx_chan_req <= bp_rise && mine_d && cnt_d[2:0] == 3'h0;
      if (bp_rise && mine_d && cnt_d[2:0] == 3'h0)
        rx_chan_idx <= ibo_chan_of(cnt_d, eff_rate);
    end
  end

  // ----------------------------------------
  // transmit side
  // ----------------------------------------
  logic tx_prev_q;
  logic tx_edge;
  logic [IBO_CNT_W-1:0] tcnt_q;
  logic [IBO_CNT_W-1:0] tcnt_d;
  logic tmine;
  logic [7:0] tx_sh_q;
  logic tx_fs_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_prev_q <= 1'b0;
    else
      tx_prev_q <= bus.tx_clk;
  end

  // [R6] pick transmit clock source
  assign tx_edge = tcs ? bp_rise : (bus.tx_clk && !tx_prev_q);

  // pin-clocked transmit free-runs; it has no bus-aligned sync to lock to
  always_comb
  begin
    if ((tcs && bus.frame_sync) || tcnt_q == ibo_frame_last(eff_rate))
      tcnt_d = '0;
    else
      tcnt_d = tcnt_q + IBO_CNT_W'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tcnt_q <= '0;
    else if (tx_edge)
      tcnt_q <= tcnt_d;
  end

  assign tmine = ((tcnt_d[5:3] & ibo_slot_mask(eff_rate)) == pos)
                 || (eff_rate == IBO_RATE_2M);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh_q <= 8'h00;
      tx_chan_data <= 8'h00;
      tx_chan_valid <= 1'b0;
      tx_chan_idx <= 5'h00;
    end
    else
    begin
      tx_chan_valid <= 1'b0;
      if (tx_edge && tmine)
      begin
        tx_sh_q <= {tx_sh_q[6:0], bus.tx_data};
        if (tcnt_d[2:0] == 3'h7)
        begin
          tx_chan_data <= {tx_sh_q[6:0], bus.tx_data};
          tx_chan_valid <= 1'b1;
          tx_chan_idx <= ibo_chan_of(tcnt_d, eff_rate);
        end
      end
    end
  end

  // [R8] sync pin is an output while the enable bit is set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_fs_q <= 1'b0;
    else if (tx_edge)
      tx_fs_q <= tcnt_d == '0;
  end
  assign bus.tx_fs = tx_fs_q;
  assign bus.tx_fs_oe = en;
endmodule
`default_nettype wire

// File: verilog/ibo_pkg.sv
// constants shared by both ends of the interleaved pcm bus slot
// Function
// [R1] interleave channels, not frames, onto bus
// [R2] rate field picks bus speed, device count
// [R3] enable bit selects interleaved or single stream
// [R4] position field picks slot, first to eighth
// [R5] every device gets a distinct slot position
// [R6] clock source bit: tx pin or backplane
// [R7] software enables receive elastic stores first; no elastic stores exist here, the bench sets the enable bit directly
// [R8] no external tx frame sync into device
// [R9] unassigned bit seven written as zero
// [R10] drive receive bus only in own slots
package ibo_pkg;
  // ----------------------------------------
  // register map of the device
  // ----------------------------------------
  localparam logic [7:0] IBO_CFG_ADDR = 8'h1C;
  localparam logic [7:0] IBO_CFG_RESET = 8'h00;
  localparam int IBO_RSVD_BIT = 7;
  localparam int IBO_TCS_BIT = 6;
  localparam int IBO_RATE_HI = 5;
  localparam int IBO_RATE_LO = 4;
  localparam int IBO_EN_BIT = 3;
  localparam int IBO_POS_HI = 2;
  localparam int IBO_POS_LO = 0;

  // ----------------------------------------
  // host software register map
  // ----------------------------------------
  localparam logic [7:0] IBO_H_CTRL = 8'h00;
  localparam logic [7:0] IBO_H_CFG_WDATA = 8'h04;
  localparam logic [7:0] IBO_H_CFG_RDREQ = 8'h08;
  localparam logic [7:0] IBO_H_CFG_RDATA = 8'h0C;
  localparam logic [7:0] IBO_H_TX_BYTE = 8'h14;
  localparam logic [7:0] IBO_H_RX_BYTE = 8'h18;
  localparam int IBO_H_RUN_BIT = 0;
  localparam int IBO_H_RATE_LO = 1;
  localparam int IBO_H_RATE_HI = 2;

  // ----------------------------------------
  // frame geometry and timing
  // ----------------------------------------
  localparam int IBO_CNT_W = 11;
  localparam int IBO_BITS_PER_CH = 8;
  localparam int IBO_CH_PER_FRAME = 32;
  localparam longint IBO_CLK_HZ = 64'd250_000_000;
  localparam longint IBO_BASE_RATE_HZ = 64'd2_048_000;
  localparam logic [7:0] IBO_IDLE_BYTE = 8'hFF;

  typedef enum logic [1:0] {
    IBO_RATE_2M = 2'b00,
    IBO_RATE_4M = 2'b01,
    IBO_RATE_8M = 2'b10,
    IBO_RATE_16M = 2'b11
  } ibo_rate_t;

  // half period of the backplane clock in system clocks, rounded down
  function automatic logic [7:0] ibo_half_cnt(input logic [1:0] rate);
    longint hz;
    hz = IBO_BASE_RATE_HZ << rate;
    return 8'(IBO_CLK_HZ / (2 * hz));
  endfunction

  function automatic logic [2:0] ibo_slot_mask(input logic [1:0] rate);
    return 3'((4'h1 << rate) - 4'h1);
  endfunction

  function automatic logic [IBO_CNT_W-1:0] ibo_frame_last(input logic [1:0] rate);
    return IBO_CNT_W'(((IBO_BITS_PER_CH * IBO_CH_PER_FRAME) << rate) - 1);
  endfunction

  function automatic logic [4:0] ibo_chan_of(input logic [IBO_CNT_W-1:0] cnt,
                                             input logic [1:0] rate);
    logic [IBO_CNT_W-1:0] s;
    s = cnt >> (3 + rate);
    return s[4:0];
  endfunction
endpackage

// File: verilog/ibo_if.sv
// pin bundle joining the device end and the backplane end
`timescale 1ns/1ps
`default_nettype none
interface ibo_if;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic cfg_wr;
  logic cfg_rd;
  logic bp_clk;
  logic frame_sync;
  logic tx_clk;
  logic tx_data;
  logic rx_d;
  logic rx_oe;
  logic rx_line;
  logic tx_fs;
  logic tx_fs_oe;

  // shared receive line idles high when nobody drives
  assign rx_line = rx_oe ? rx_d : 1'b1;

  modport dev (
    input cfg_addr, cfg_wdata, cfg_wr, cfg_rd, bp_clk, frame_sync, tx_clk, tx_data,
    output cfg_rdata, rx_d, rx_oe, tx_fs, tx_fs_oe
  );
  modport host (
    output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, bp_clk, frame_sync, tx_clk, tx_data,
    input cfg_rdata, rx_line, tx_fs, tx_fs_oe
  );
endinterface
`default_nettype wire

// File: verilog/ibo_host.sv
// backplane end: software port, device config access, bus clock and sync
`timescale 1ns/1ps
`default_nettype none
module ibo_host
  import ibo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ibo_if.host bus,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [2:0] ctrl_q;
  logic [7:0] txb_q;
  logic [7:0] cfg_rd_q;
  logic [7:0] rxb_q;
  logic cfg_wr_q;
  logic cfg_rd_req_q;
  logic cfg_rd_wait_q;
  logic [7:0] cfg_wdata_q;
  logic [1:0] rate;

  assign rate = ctrl_q[IBO_H_RATE_HI:IBO_H_RATE_LO];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= 3'h0;
      txb_q <= IBO_IDLE_BYTE;
    end
    else if (sw_wr && sw_addr == IBO_H_CTRL)
      ctrl_q <= sw_wdata[2:0];
    else if (sw_wr && sw_addr == IBO_H_TX_BYTE)
      txb_q <= sw_wdata;
  end

  // [R9] bit seven always sent as zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_wr_q <= 1'b0;
      cfg_rd_req_q <= 1'b0;
      cfg_rd_wait_q <= 1'b0;
      cfg_wdata_q <= 8'h00;
      cfg_rd_q <= 8'h00;
    end
    else
    begin
      cfg_wr_q <= sw_wr && sw_addr == IBO_H_CFG_WDATA;
      cfg_rd_req_q <= sw_wr && sw_addr == IBO_H_CFG_RDREQ;
      cfg_rd_wait_q <= cfg_rd_req_q;
      if (sw_wr && sw_addr == IBO_H_CFG_WDATA)
        cfg_wdata_q <= {1'b0, sw_wdata[6:0]};
      if (cfg_rd_wait_q)
        cfg_rd_q <= bus.cfg_rdata;
    end
  end
  assign bus.cfg_addr = IBO_CFG_ADDR;
  assign bus.cfg_wdata = cfg_wdata_q;
  assign bus.cfg_wr = cfg_wr_q;
  assign bus.cfg_rd = cfg_rd_req_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_rdata <= 8'h00;
    else if (!sw_rd)
      sw_rdata <= 8'h00;
    else
      unique case (sw_addr)
        IBO_H_CTRL: sw_rdata <= {5'h00, ctrl_q};
        IBO_H_CFG_RDATA: sw_rdata <= cfg_rd_q;
        IBO_H_TX_BYTE: sw_rdata <= txb_q;
        IBO_H_RX_BYTE: sw_rdata <= rxb_q;
        default: sw_rdata <= 8'h00;
      endcase
  end

  // ----------------------------------------
  // backplane clock, frame sync, tx data
  // ----------------------------------------
  logic [7:0] div_q;
  logic bp_q;
  logic fs_q;
  logic txd_q;
  logic [IBO_CNT_W-1:0] hcnt_q;
  logic fall;

  // [R2] bus clock rate from rate field
  assign fall = ctrl_q[IBO_H_RUN_BIT] && bp_q && div_q == 8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 8'h00;
      bp_q <= 1'b0;
    end
    else if (!ctrl_q[IBO_H_RUN_BIT])
    begin
      div_q <= 8'h00;
      bp_q <= 1'b0;
    end
    else if (div_q == 8'h00)
    begin
      div_q <= ibo_half_cnt(rate) - 8'h01;
      bp_q <= !bp_q;
    end
    else
      div_q <= div_q - 8'h01;
  end

  // new bit set up on the falling edge, taken by the device on the rise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hcnt_q <= ibo_frame_last(IBO_RATE_2M);
      fs_q <= 1'b0;
      txd_q <= 1'b1;
      rxb_q <= IBO_IDLE_BYTE;
    end
    else if (fall)
    begin
      hcnt_q <= (hcnt_q >= ibo_frame_last(rate)) ? '0 : hcnt_q + IBO_CNT_W'(1);
      fs_q <= hcnt_q >= ibo_frame_last(rate);
      txd_q <= txb_q[3'h7 - 3'(hcnt_q + IBO_CNT_W'(1))];
      rxb_q <= {rxb_q[6:0], bus.rx_line};
    end
  end
  assign bus.bp_clk = bp_q;
  assign bus.tx_clk = bp_q;
  assign bus.frame_sync = fs_q;
  assign bus.tx_data = txd_q;
endmodule
`default_nettype wire

// File: dv/ibo_checker.sv
// assertions on the pins joining the two ends
`timescale 1ns/1ps
`default_nettype none
module ibo_checker
  import ibo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic bp_clk,
  input wire logic frame_sync,
  input wire logic rx_oe,
  input wire logic tx_fs_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // config port
  // ----------------------------------------
  cfg_addr_a: assert property ((cfg_wr || cfg_rd) |-> cfg_addr == IBO_CFG_ADDR)
    else $error("config access off its address");
  rsvd_wdata_a: assert property (cfg_wr |-> !cfg_wdata[IBO_RSVD_BIT])
    else $error("reserved bit written as one");
  rsvd_rdata_a: assert property ($past(cfg_rd) |-> !cfg_rdata[IBO_RSVD_BIT])
    else $error("reserved bit read as one");
  rdata_idle_a: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00)
    else $error("read data outside its cycle");
  // back-to-back strobes are legal, so judge what a write does instead
  fs_oe_follow_a: assert property (cfg_wr |=> tx_fs_oe == $past(cfg_wdata[IBO_EN_BIT]))
    else $error("sync pin direction does not follow the enable bit");
  fs_oe_cfg_a: assert property ($changed(tx_fs_oe) |->
    ($past(cfg_wr) || $past(cfg_wr, 2) || $past(cfg_wr, 3)))
    else $error("sync pin direction moved without a write");
  // ----------------------------------------
  // bus timing
  // ----------------------------------------
  // host samples on the falling clock, so drive must settle while high
  rx_edge_a: assert property ($changed(rx_oe) |-> bp_clk)
    else $error("receive drive moved while bus clock low");
  sync_fall_a: assert property ($changed(frame_sync) |-> !bp_clk)
    else $error("frame sync moved while bus clock high");
  no_both_a: assert property (!(cfg_wr && cfg_rd))
    else $error("write and read strobes together");
  cover property (cfg_rd);
  cover property ($rose(rx_oe));
  cover property ($rose(frame_sync));
endmodule
`default_nettype wire

// File: dv/ibo_tb.sv
// self-checking bench for both ends of the interleaved bus
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ibo_pkg::*;
;
  logic clk;
  logic rst_n;
  logic sw_wr;
  logic sw_rd;
  logic [7:0] sw_addr;
  logic [7:0] sw_wdata;
  logic [7:0] sw_rdata;
  logic [7:0] rx_chan_data;
  logic [7:0] tx_chan_data;
  logic [7:0] cfg_value;
  logic tx_chan_valid;
  logic rx_chan_req;
  logic [4:0] rx_chan_idx;
  logic [4:0] tx_chan_idx;
  int bad_count = 0;
  int tests_run = 0;
  ibo_if bus_if ();
  ibo_host i_ibo_host (.clk(clk), .rst_n(rst_n), .bus(bus_if), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  ibo_device i_ibo_device (.clk(clk), .rst_n(rst_n), .bus(bus_if),
    .rx_chan_data(rx_chan_data), .rx_chan_req(rx_chan_req), .rx_chan_idx(rx_chan_idx),
    .tx_chan_data(tx_chan_data), .tx_chan_valid(tx_chan_valid), .tx_chan_idx(tx_chan_idx),
    .cfg_value(cfg_value));
  ibo_checker i_ibo_checker (.clk(clk), .rst_n(rst_n), .cfg_addr(bus_if.cfg_addr),
    .cfg_wdata(bus_if.cfg_wdata), .cfg_rdata(bus_if.cfg_rdata), .cfg_wr(bus_if.cfg_wr),
    .cfg_rd(bus_if.cfg_rd), .bp_clk(bus_if.bp_clk), .frame_sync(bus_if.frame_sync),
    .rx_oe(bus_if.rx_oe), .tx_fs_oe(bus_if.tx_fs_oe));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic cfg_get(input logic [7:0] e);
    logic [7:0] v;
    sw_write(IBO_H_CFG_RDREQ, 8'h00);
    repeat (3) @(posedge clk);
    sw_read(IBO_H_CFG_RDATA, v);
    check8(v, e);
    #1 check8(cfg_value, e);
  endtask
  task automatic cfg_set(input logic [7:0] d);
    sw_write(IBO_H_CFG_WDATA, d);
    repeat (3) @(posedge clk);
    cfg_get(d & 8'h7F);
  endtask
  task automatic half_len(output int n);
    logic b;
    repeat (2)
    begin
      b = bus_if.bp_clk;
      n = 0;
      while (bus_if.bp_clk === b && n < 300)
      begin
        @(posedge clk);
        #1 n++;
      end
    end
  endtask
  // window of 64 bus bits holds every slot pattern at least once, whatever the phase
  task automatic slot_win(input logic [1:0] r, input logic [7:0] c, input int e);
    int n;
    logic [7:0] v;
    sw_write(IBO_H_CTRL, {5'h00, r, 1'b1});
    cfg_set(c);
    repeat (2) @(negedge bus_if.bp_clk);
    for (int k = 0; k < 64 && bus_if.rx_oe !== 1'b0; k++) @(negedge bus_if.bp_clk);
    n = 0;
    repeat (64)
    begin
      @(negedge bus_if.bp_clk);
      n += int'(bus_if.rx_oe === 1'b1);
      if (bus_if.rx_oe === 1'b1) v = {v[6:0], bus_if.rx_line};
    end
    check8(8'(n), 8'(e));
    if (e == 8 || e == 16) check8(v, rx_chan_data);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    logic [7:0] v;
    cfg_get(8'h00);
    sw_read(8'h40, v);
    check8(v, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_rates();
    int n;
    for (int r = 0; r < 4; r++)
    begin
      sw_write(IBO_H_CTRL, 8'(1 + 2 * r));
      half_len(n);
      half_len(n);
      check8(8'(n), 8'(125_000_000 / (2_048_000 << r)));
    end
    $display("test rates done");
  endtask
  task automatic test_slots();
    for (int p = 0; p < 8; p++) slot_win(2'd3, 8'h38 | 8'(p), 8);
    slot_win(2'd2, 8'hAB, 16);
    slot_win(2'd1, 8'h1D, 0);
    slot_win(2'd0, 8'h08, 64);
    slot_win(2'd3, 8'h37, 64);
    $display("test slots done");
  endtask
  task automatic test_tx();
    int seen;
    int reqs;
    logic fs_out;
    sw_write(IBO_H_TX_BYTE, 8'h6B);
    cfg_set(8'hFA);
    // the bus-clocked tx counter only lines up at a fresh frame sync
    for (int k = 0; k < 100 && bus_if.frame_sync !== 1'b0; k++) @(posedge clk);
    for (int k = 0; k < 30000 && bus_if.frame_sync !== 1'b1; k++) @(posedge clk);
    seen = 0;
    reqs = 0;
    fs_out = 1'b0;
    // own slot is bits 16..23 of each 64: captures in channels 0 and 1
    for (int k = 0; k < 4000 && seen < 2; k++)
    begin
      @(posedge clk);
      #1 seen += int'(tx_chan_valid === 1'b1);
      reqs += int'(rx_chan_req === 1'b1);
      fs_out = fs_out | (bus_if.tx_fs === 1'b1);
    end
    check8(8'(seen), 8'h02);
    check8(tx_chan_data, 8'h6B);
    check8({3'h0, tx_chan_idx}, 8'h01);
    check8(8'(reqs), 8'h02);
    check8({3'h0, rx_chan_idx}, 8'h01);
    check8({7'h00, fs_out}, 8'h01);
    $display("test tx done");
  endtask
  task automatic tally_and_finish();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    sw_addr = 8'h00;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    rx_chan_data = 8'h1D;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_rates();
    test_slots();
    test_tx();
    tally_and_finish();
  end
  initial
  begin
    #400_000;
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
